// File: iefb_bank.sv
/*
 Interrupt enable and flag bank with an AXI4-Lite register slave, edge detection for
 the four pins 2..5, group folding, fixed-priority selection and service clearing.
 Assumes peripheral event inputs are one-cycle pulses on core_clk, external pins are
 asynchronous, and the core pulses irq_ack for one cycle when it takes irq_req.
*/
// Implementation choices: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/100ps
module iefb_bank
   import iefb_pkg::*;
(
   input  wire logic        core_clk,
   input  wire logic        nrst,
   input  wire logic [31:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [31:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic [5:0]  ext_pin,
   input  wire logic        ext_pin0_event,
   input  wire logic        ext_pin1_event,
   input  wire logic        adc_done_event,
   input  wire logic [1:0]  timebase_event,
   input  wire logic        serial_if_event,
   input  wire logic [1:0]  uart_event,
   input  wire logic [3:0]  ptimer_event,
   input  wire logic [3:0]  lvd_eeprom_stimer_event,
   input  wire logic [2:0]  atimer_event,
   input  wire logic        irq_ack,
   output logic             irq_req,
   output logic [3:0]       irq_vector
);

   ////////////////////////////////////////////////////////////////////////////////
   // Register state.

   logic [7:0]  edge_select_pins_4_5_q;
   logic [7:0]  control_global_adc_pin01_q;
   logic [7:0]  control_group_flags_q;
   logic [7:0]  control_pins45_timebase_q;
   logic [7:0]  control_serial_uarts_q;
   logic [7:0]  group_periodic_timers_q;
   logic [7:0]  group_lvd_eeprom_stdtimer_q;
   logic [7:0]  group_audio_timer_q;
   logic [7:0]  group_pins_2_3_q;
   logic [5:2]  pin_s1_q;
   logic [5:2]  pin_s2_q;
   logic [5:2]  pin_prev_q;
   logic [3:0]  vec_q;
   logic        req_q;

   // Write channel capture; address and data can come in either order.
   logic        aw_held_q;
   logic        w_held_q;
   logic [7:0]  waddr_q;
   logic [7:0]  wdata_q;
   logic        wlane_q;
   logic        bvalid_q;
   logic [1:0]  bresp_q;
   logic        rvalid_q;
   logic [31:0] rdata_q;
   logic [1:0]  rresp_q;

   ////////////////////////////////////////////////////////////////////////////////
   // Functions.

   function automatic logic iefb_edge(input logic [1:0] sel, input logic prev,
                                      input logic cur);
      logic hit;
      hit = 1'b0;
      case (sel)
         IEFB_EDGE_RISE: hit = !prev && cur;
         IEFB_EDGE_FALL: hit = prev && !cur;
         IEFB_EDGE_BOTH: hit = prev != cur;
         default:        hit = 1'b0;
      endcase
      return hit;
   endfunction : iefb_edge

   // A register's pending-and-enabled set: flags in high nibble, enables in low.
   function automatic logic [3:0] iefb_live(input logic [7:0] r);
      return r[7:4] & r[3:0];
   endfunction : iefb_live

   ////////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers and edge detection; pins 0 and 1 arrive as edge events.

   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         pin_s1_q   <= '0;
         pin_s2_q   <= '0;
         pin_prev_q <= '0;
      end else begin
         pin_s1_q   <= ext_pin[5:2];
         pin_s2_q   <= pin_s1_q;
         pin_prev_q <= pin_s2_q;
      end
   end

   logic pin2_hit, pin3_hit, pin4_hit, pin5_hit;

   // Pins 2 and 3 have no edge select in this bank; both edges count.
   assign pin2_hit = iefb_edge(IEFB_EDGE_BOTH, pin_prev_q[2], pin_s2_q[2]);
   assign pin3_hit = iefb_edge(IEFB_EDGE_BOTH, pin_prev_q[3], pin_s2_q[3]);
   assign pin4_hit = iefb_edge(edge_select_pins_4_5_q[IEFB_EDGE4_LSB +: 2],
                               pin_prev_q[4], pin_s2_q[4]);
   assign pin5_hit = iefb_edge(edge_select_pins_4_5_q[IEFB_EDGE5_LSB +: 2],
                               pin_prev_q[5], pin_s2_q[5]);

   ////////////////////////////////////////////////////////////////////////////////
   // Priority selection.

   logic [3:0] grp_any;
   logic [3:0] sel_vec;
   logic       sel_any;
   logic       gie;

   assign gie = control_global_adc_pin01_q[IEFB_BIT_GIE];
   assign grp_any = {|iefb_live(group_pins_2_3_q), |iefb_live(group_audio_timer_q),
                     |iefb_live(group_lvd_eeprom_stdtimer_q),
                     |iefb_live(group_periodic_timers_q)};

   always_comb begin
      logic [3:0] g;
      logic [3:0] t;
      logic [3:0] u;
      logic [7:0] c0;
      c0 = control_global_adc_pin01_q;
      g = iefb_live(control_group_flags_q);
      t = iefb_live(control_pins45_timebase_q);
      u = iefb_live(control_serial_uarts_q);
      sel_vec = 4'h0;
      if (c0[IEFB_BIT_PIN0_FL] && c0[IEFB_BIT_PIN0_EN])      sel_vec = IEFB_VEC_PIN0;
      else if (c0[IEFB_BIT_PIN1_FL] && c0[IEFB_BIT_PIN1_EN]) sel_vec = IEFB_VEC_PIN1;
      else if (c0[IEFB_BIT_ADC_FL] && c0[IEFB_BIT_ADC_EN])   sel_vec = IEFB_VEC_ADC;
      else if (g[0]) sel_vec = IEFB_VEC_GRP0;
      else if (g[1]) sel_vec = IEFB_VEC_GRP1;
      else if (g[2]) sel_vec = IEFB_VEC_GRP2;
      else if (g[3]) sel_vec = IEFB_VEC_GRP3;
      else if (t[0]) sel_vec = IEFB_VEC_TB0;
      else if (t[1]) sel_vec = IEFB_VEC_TB1;
      else if (t[2]) sel_vec = IEFB_VEC_PIN4;
      else if (t[3]) sel_vec = IEFB_VEC_PIN5;
      else if (u[0]) sel_vec = IEFB_VEC_UR0;
      else if (u[1]) sel_vec = IEFB_VEC_UR1;
      else if (u[2]) sel_vec = IEFB_VEC_SER;
      else           sel_vec = 4'h0;
   end

   assign sel_any = (sel_vec != 4'h0);

   // Request is held until the core acknowledges; vector is frozen while requesting.
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         req_q <= 1'b0;
         vec_q <= 4'h0;
      end else if (req_q && irq_ack) begin
         req_q <= 1'b0;
      end else if (!req_q) begin
         req_q <= gie && sel_any;
         vec_q <= sel_vec;
      end
   end

   logic ack;
   assign ack = req_q && irq_ack;

   ////////////////////////////////////////////////////////////////////////////////
   // Bus decode.

   logic       aw_go;
   logic       w_go;
   logic       wr_fire;
   logic       ar_go;
   logic       awready_q;
   logic       wready_q;
   logic       arready_q;

   // A beat is taken only while its ready flop is shown high.
   assign aw_go   = s_axi_awvalid && awready_q;
   assign w_go    = s_axi_wvalid && wready_q;
   assign wr_fire = aw_held_q && w_held_q && !bvalid_q;
   assign ar_go   = s_axi_arvalid && arready_q;

   // Hardware sets win over a software write in the same cycle.
   function automatic logic [7:0] iefb_next(input logic [7:0] cur, input logic [7:0] ofs,
                                            input logic [7:0] mask, input logic [7:0] set,
                                            input logic [7:0] clr);
      logic [7:0] v;
      v = (wr_fire && wlane_q && waddr_q == ofs) ? wdata_q & mask : cur;
      return ((v & ~clr) | set) & mask;
   endfunction : iefb_next

   ////////////////////////////////////////////////////////////////////////////////
   // Register updates and service clears.

   logic [7:0] c0_clr;
   logic [7:0] g_clr;
   logic [7:0] t_clr;
   logic [7:0] u_clr;

   // Service clears are pulse-wide on ack and target the serviced flag and the global enable GIE.
   always_comb begin
      c0_clr = 8'h00;
      g_clr  = 8'h00;
      t_clr  = 8'h00;
      u_clr  = 8'h00;
      if (ack) begin
         c0_clr[IEFB_BIT_GIE] = 1'b1;
         case (vec_q)
            IEFB_VEC_PIN0: c0_clr[IEFB_BIT_PIN0_FL] = 1'b1;
            IEFB_VEC_PIN1: c0_clr[IEFB_BIT_PIN1_FL] = 1'b1;
            IEFB_VEC_ADC:  c0_clr[IEFB_BIT_ADC_FL]  = 1'b1;
            IEFB_VEC_GRP0: g_clr[IEFB_FLAG_LSB + 0] = 1'b1;
            IEFB_VEC_GRP1: g_clr[IEFB_FLAG_LSB + 1] = 1'b1;
            IEFB_VEC_GRP2: g_clr[IEFB_FLAG_LSB + 2] = 1'b1;
            IEFB_VEC_GRP3: g_clr[IEFB_FLAG_LSB + 3] = 1'b1;
            IEFB_VEC_TB0:  t_clr[IEFB_FLAG_LSB + 0] = 1'b1;
            IEFB_VEC_TB1:  t_clr[IEFB_FLAG_LSB + 1] = 1'b1;
            IEFB_VEC_PIN4: t_clr[IEFB_FLAG_LSB + 2] = 1'b1;
            IEFB_VEC_PIN5: t_clr[IEFB_FLAG_LSB + 3] = 1'b1;
            IEFB_VEC_UR0:  u_clr[IEFB_FLAG_LSB + 0] = 1'b1;
            IEFB_VEC_UR1:  u_clr[IEFB_FLAG_LSB + 1] = 1'b1;
            IEFB_VEC_SER:  u_clr[IEFB_FLAG_LSB + 2] = 1'b1;
            default:       c0_clr = c0_clr;
         endcase
      end
   end

   // Group flags are set only while an enabled source is pending; source flags
   // inside the groups are never cleared by service.
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         edge_select_pins_4_5_q      <= IEFB_RESET_VAL;
         control_global_adc_pin01_q  <= IEFB_RESET_VAL;
         control_group_flags_q       <= IEFB_RESET_VAL;
         control_pins45_timebase_q   <= IEFB_RESET_VAL;
         control_serial_uarts_q      <= IEFB_RESET_VAL;
         group_periodic_timers_q     <= IEFB_RESET_VAL;
         group_lvd_eeprom_stdtimer_q <= IEFB_RESET_VAL;
         group_audio_timer_q         <= IEFB_RESET_VAL;
         group_pins_2_3_q            <= IEFB_RESET_VAL;
      end else begin
         edge_select_pins_4_5_q <= iefb_next(edge_select_pins_4_5_q, IEFB_OFS_EDGE45,
            IEFB_MASK_EDGE45, 8'h00, 8'h00);
         control_global_adc_pin01_q <= iefb_next(control_global_adc_pin01_q, IEFB_OFS_CTRL0,
            IEFB_MASK_CTRL0, {1'b0, adc_done_event, ext_pin1_event, ext_pin0_event, 4'h0},
            c0_clr);
         control_group_flags_q <= iefb_next(control_group_flags_q, IEFB_OFS_CTRL1,
            IEFB_MASK_FULL, {grp_any & ~g_clr[7:4], 4'h0}, g_clr);
         control_pins45_timebase_q <= iefb_next(control_pins45_timebase_q, IEFB_OFS_CTRL2,
            IEFB_MASK_FULL, {pin5_hit, pin4_hit, timebase_event, 4'h0}, t_clr);
         control_serial_uarts_q <= iefb_next(control_serial_uarts_q, IEFB_OFS_CTRL3,
            IEFB_MASK_CTRL3, {1'b0, serial_if_event, uart_event, 4'h0}, u_clr);
         group_periodic_timers_q <= iefb_next(group_periodic_timers_q, IEFB_OFS_GRP0,
            IEFB_MASK_FULL, {ptimer_event, 4'h0}, 8'h00);
         group_lvd_eeprom_stdtimer_q <= iefb_next(group_lvd_eeprom_stdtimer_q, IEFB_OFS_GRP1,
            IEFB_MASK_FULL, {lvd_eeprom_stimer_event, 4'h0}, 8'h00);
         group_audio_timer_q <= iefb_next(group_audio_timer_q, IEFB_OFS_GRP2,
            IEFB_MASK_GRP2, {1'b0, atimer_event, 4'h0}, 8'h00);
         group_pins_2_3_q <= iefb_next(group_pins_2_3_q, IEFB_OFS_GRP3,
            IEFB_MASK_GRP3, {2'h0, pin3_hit, pin2_hit, 4'h0}, 8'h00);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // AXI4-Lite write path.

   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         aw_held_q <= 1'b0;
         w_held_q  <= 1'b0;
         waddr_q   <= 8'h00;
         wdata_q   <= 8'h00;
         wlane_q   <= 1'b0;
         bvalid_q  <= 1'b0;
         bresp_q   <= IEFB_RESP_OKAY;
      end else begin
         if (aw_go) begin
            aw_held_q <= 1'b1;
            waddr_q   <= (s_axi_awaddr[31:8] == 24'h0) ? s_axi_awaddr[7:0] : 8'hFF;
         end
         if (w_go) begin
            w_held_q <= 1'b1;
            wdata_q  <= s_axi_wdata[7:0];
            wlane_q  <= s_axi_wstrb[0];
         end
         if (wr_fire) begin
            aw_held_q <= 1'b0;
            w_held_q  <= 1'b0;
            bvalid_q  <= 1'b1;
            bresp_q   <= (waddr_q <= IEFB_OFS_VECTOR && waddr_q[1:0] == 2'h0)
                         ? IEFB_RESP_OKAY : IEFB_RESP_SLVERR;
         end else if (bvalid_q && s_axi_bready) begin
            bvalid_q <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // AXI4-Lite read path.

   logic [7:0] rd_byte;
   logic       rd_ok;

   always_comb begin
      rd_ok   = 1'b1;
      rd_byte = 8'h00;
      case (s_axi_araddr)
         32'(IEFB_OFS_EDGE45): rd_byte = edge_select_pins_4_5_q;
         32'(IEFB_OFS_CTRL0):  rd_byte = control_global_adc_pin01_q;
         32'(IEFB_OFS_CTRL1):  rd_byte = control_group_flags_q;
         32'(IEFB_OFS_CTRL2):  rd_byte = control_pins45_timebase_q;
         32'(IEFB_OFS_CTRL3):  rd_byte = control_serial_uarts_q;
         32'(IEFB_OFS_GRP0):   rd_byte = group_periodic_timers_q;
         32'(IEFB_OFS_GRP1):   rd_byte = group_lvd_eeprom_stdtimer_q;
         32'(IEFB_OFS_GRP2):   rd_byte = group_audio_timer_q;
         32'(IEFB_OFS_GRP3):   rd_byte = group_pins_2_3_q;
         32'(IEFB_OFS_VECTOR): rd_byte = {req_q, 3'h0, vec_q};
         default:              rd_ok   = 1'b0;
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         rvalid_q <= 1'b0;
         rdata_q  <= 32'h0000_0000;
         rresp_q  <= IEFB_RESP_OKAY;
      end else if (ar_go) begin
         rvalid_q <= 1'b1;
         rdata_q  <= {24'h00_0000, rd_byte};
         rresp_q  <= rd_ok ? IEFB_RESP_OKAY : IEFB_RESP_SLVERR;
      end else if (rvalid_q && s_axi_rready) begin
         rvalid_q <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Ready drops the cycle after a beat is taken and stays low while it is pending.
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         awready_q <= 1'b0;
         wready_q  <= 1'b0;
         arready_q <= 1'b0;
      end else begin
         awready_q <= !aw_held_q && !aw_go && !bvalid_q && !wr_fire;
         wready_q  <= !w_held_q && !w_go && !bvalid_q && !wr_fire;
         arready_q <= !rvalid_q && !ar_go;
      end
   end

   assign s_axi_awready = awready_q;
   assign s_axi_wready  = wready_q;
   assign s_axi_arready = arready_q;
   assign s_axi_bvalid  = bvalid_q;
   assign s_axi_bresp   = bresp_q;
   assign s_axi_rvalid  = rvalid_q;
   assign s_axi_rdata   = rdata_q;
   assign s_axi_rresp   = rresp_q;
   assign irq_req       = req_q;
   assign irq_vector    = vec_q;

endmodule : iefb_bank

// File: iefb_bank_asserts.sv
/* Port-level checker for iefb_bank.
   Assumes the bind below and the package offsets and masks. */
`timescale 1ns/100ps
module iefb_bank_asserts
   import iefb_pkg::*;
(
   input wire logic        core_clk,
   input wire logic        nrst,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic [31:0] s_axi_araddr,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0]  s_axi_rresp,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic        irq_ack,
   input wire logic        irq_req,
   input wire logic [3:0]  irq_vector
);
   logic [7:0] rd_addr_q;
   logic [7:0] rd_mask;
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         rd_addr_q <= 8'h00;
      end else if (s_axi_arvalid && s_axi_arready) begin
         rd_addr_q <= s_axi_araddr[7:0];
      end
   end
   always_comb begin
      case (rd_addr_q)
         IEFB_OFS_EDGE45: rd_mask = IEFB_MASK_EDGE45;
         IEFB_OFS_CTRL0:  rd_mask = IEFB_MASK_CTRL0;
         IEFB_OFS_CTRL3:  rd_mask = IEFB_MASK_CTRL3;
         IEFB_OFS_GRP2:   rd_mask = IEFB_MASK_GRP2;
         IEFB_OFS_GRP3:   rd_mask = IEFB_MASK_GRP3;
         IEFB_OFS_VECTOR: rd_mask = 8'h8F;
         default:         rd_mask = IEFB_MASK_FULL;
      endcase
   end
   ////////////////////////////////////////////////////////////////////////////////
   default clocking @(posedge core_clk);
   endclocking
   default disable iff (!nrst);
   a_write_answer: assert property (
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
      else $error("write response missing");
   a_read_answer: assert property (
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read data missing");
   a_bresp_hold: assert property (
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   a_rdata_hold: assert property (
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
   a_unimpl_zero: assert property (
      s_axi_rvalid && s_axi_rresp == IEFB_RESP_OKAY |-> (s_axi_rdata & ~{24'h0, rd_mask}) == 0)
      else $error("unimplemented bits read nonzero");
   a_req_holds: assert property (
      irq_req && !irq_ack |=> irq_req)
      else $error("request dropped before acceptance");
   a_ack_drops: assert property (
      irq_req && irq_ack |=> !irq_req)
      else $error("request stayed after acceptance");
   a_vec_frozen: assert property (
      irq_req && !irq_ack |=> $stable(irq_vector))
      else $error("vector moved while pending");
   a_vec_legal: assert property (
      irq_req |-> irq_vector inside {[4'h1:4'hE]})
      else $error("vector out of range");
endmodule : iefb_bank_asserts

bind iefb_bank iefb_bank_asserts chk (.*);

// File: iefb_core_model.sv
/* Model of the processor core that accepts interrupts from iefb_bank.
   Assumes one clock, core_clk, and the synchronous active-low reset nrst. */
`timescale 1ns/100ps
module iefb_core_model
(
   input  wire logic       core_clk,
   input  wire logic       nrst,
   input  wire logic       irq_req,
   input  wire logic [3:0] irq_vector,
   input  wire logic [3:0] ack_delay,
   output logic            irq_ack,
   output logic [3:0]      taken_vec,
   output logic [7:0]      taken_cnt
);
   logic [3:0] wait_q;
   ////////////////////////////////////////////////////////////////////////////////
   // A nonzero ack_delay keeps a request waiting, which shows that it is held.
   always_ff @(posedge core_clk) begin
      irq_ack <= 1'b0;
      if (!nrst) begin
         wait_q    <= 4'h0;
         taken_vec <= 4'h0;
         taken_cnt <= 8'h00;
      end else if (irq_req && !irq_ack) begin
         if (wait_q >= ack_delay) begin
            irq_ack   <= 1'b1;
            taken_vec <= irq_vector;
            taken_cnt <= taken_cnt + 8'h01;
            wait_q    <= 4'h0;
         end else begin
            wait_q <= wait_q + 4'h1;
         end
      end
   end
endmodule : iefb_core_model

// File: iefb_pkg.sv
/*
 Constants for the interrupt enable and flag bank: register offsets, bit positions,
 edge-select codes, reset values and vector indices.
 Assumes a 32-bit AXI4-Lite slave with each 8-bit register in the low byte of a word.
*/
package iefb_pkg;

   localparam logic [7:0] IEFB_OFS_EDGE45 = 8'h00;
   localparam logic [7:0] IEFB_OFS_CTRL0  = 8'h04;
   localparam logic [7:0] IEFB_OFS_CTRL1  = 8'h08;
   localparam logic [7:0] IEFB_OFS_CTRL2  = 8'h0C;
   localparam logic [7:0] IEFB_OFS_CTRL3  = 8'h10;
   localparam logic [7:0] IEFB_OFS_GRP0   = 8'h14;
   localparam logic [7:0] IEFB_OFS_GRP1   = 8'h18;
   localparam logic [7:0] IEFB_OFS_GRP2   = 8'h1C;
   localparam logic [7:0] IEFB_OFS_GRP3   = 8'h20;
   localparam logic [7:0] IEFB_OFS_VECTOR = 8'h24;

   // Implemented-bit masks per register.
   localparam logic [7:0] IEFB_MASK_EDGE45 = 8'h0F;
   localparam logic [7:0] IEFB_MASK_CTRL0  = 8'h7F;
   localparam logic [7:0] IEFB_MASK_FULL   = 8'hFF;
   localparam logic [7:0] IEFB_MASK_CTRL3  = 8'h77;
   localparam logic [7:0] IEFB_MASK_GRP2   = 8'h77;
   localparam logic [7:0] IEFB_MASK_GRP3   = 8'h33;
   localparam logic [7:0] IEFB_RESET_VAL   = 8'h00;

   localparam int IEFB_BIT_GIE      = 0;
   localparam int IEFB_BIT_PIN0_EN  = 1;
   localparam int IEFB_BIT_PIN1_EN  = 2;
   localparam int IEFB_BIT_ADC_EN   = 3;
   localparam int IEFB_BIT_PIN0_FL  = 4;
   localparam int IEFB_BIT_PIN1_FL  = 5;
   localparam int IEFB_BIT_ADC_FL   = 6;
   localparam int IEFB_FLAG_LSB     = 4;
   localparam int IEFB_EDGE4_LSB    = 0;
   localparam int IEFB_EDGE5_LSB    = 2;

   localparam logic [1:0] IEFB_EDGE_OFF  = 2'h0;
   localparam logic [1:0] IEFB_EDGE_RISE = 2'h1;
   localparam logic [1:0] IEFB_EDGE_FALL = 2'h2;
   localparam logic [1:0] IEFB_EDGE_BOTH = 2'h3;

   // Vector numbers in descending priority order.
   localparam logic [3:0] IEFB_VEC_PIN0 = 4'h1;
   localparam logic [3:0] IEFB_VEC_PIN1 = 4'h2;
   localparam logic [3:0] IEFB_VEC_ADC  = 4'h3;
   localparam logic [3:0] IEFB_VEC_GRP0 = 4'h4;
   localparam logic [3:0] IEFB_VEC_GRP1 = 4'h5;
   localparam logic [3:0] IEFB_VEC_GRP2 = 4'h6;
   localparam logic [3:0] IEFB_VEC_GRP3 = 4'h7;
   localparam logic [3:0] IEFB_VEC_TB0  = 4'h8;
   localparam logic [3:0] IEFB_VEC_TB1  = 4'h9;
   localparam logic [3:0] IEFB_VEC_PIN4 = 4'hA;
   localparam logic [3:0] IEFB_VEC_PIN5 = 4'hB;
   localparam logic [3:0] IEFB_VEC_UR0  = 4'hC;
   localparam logic [3:0] IEFB_VEC_UR1  = 4'hD;
   localparam logic [3:0] IEFB_VEC_SER  = 4'hE;

   localparam logic [1:0] IEFB_RESP_OKAY   = 2'h0;
   localparam logic [1:0] IEFB_RESP_SLVERR = 2'h2;

endpackage : iefb_pkg

// File: testbench.sv
/* Self-checking bench for iefb_bank with a core model.
   Assumes a 250 MHz core_clk and the package offsets and vector codes. */
`timescale 1ns/100ps
module testbench
   import iefb_pkg::*;
;
   typedef struct packed {logic [7:0] a; logic [7:0] wd; logic [7:0] ev; logic [7:0] rd;
                          logic [1:0] rs;} iefb_row_t;
   localparam iefb_row_t ROWS [10] = '{
      '{IEFB_OFS_EDGE45, 8'hFF, 8'h00, 8'h0F, IEFB_RESP_OKAY},
      '{IEFB_OFS_CTRL0,  8'h7E, 8'h70, 8'h7E, IEFB_RESP_OKAY},
      '{IEFB_OFS_CTRL1,  8'hFF, 8'h00, 8'hFF, IEFB_RESP_OKAY},
      '{IEFB_OFS_CTRL2,  8'hFF, 8'h30, 8'hFF, IEFB_RESP_OKAY},
      '{IEFB_OFS_CTRL3,  8'hFF, 8'h70, 8'h77, IEFB_RESP_OKAY},
      '{IEFB_OFS_GRP0,   8'hFF, 8'hF0, 8'hFF, IEFB_RESP_OKAY},
      '{IEFB_OFS_GRP1,   8'hFF, 8'hF0, 8'hFF, IEFB_RESP_OKAY},
      '{IEFB_OFS_GRP2,   8'hFF, 8'h70, 8'h77, IEFB_RESP_OKAY},
      '{IEFB_OFS_GRP3,   8'hFF, 8'h00, 8'h33, IEFB_RESP_OKAY},
      '{8'h28,           8'hFF, 8'h00, 8'h00, IEFB_RESP_SLVERR}};
   logic        core_clk = 1'b0;
   logic        nrst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
   logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic        irq_ack, irq_req;
   logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic [3:0]  s_axi_wstrb, irq_vector, ack_delay, taken_vec;
   logic [7:0]  taken_cnt, cnt_q;
   logic [5:0]  ext_pin;
   logic [18:0] evt;
   int          error_cnt = 0;
   int          samples_checked = 0;
   always #2 core_clk = ~core_clk;
   iefb_bank uut (.*, .ext_pin0_event(evt[0]), .ext_pin1_event(evt[1]),
      .adc_done_event(evt[2]), .timebase_event(evt[4:3]), .serial_if_event(evt[5]),
      .uart_event(evt[7:6]), .ptimer_event(evt[11:8]), .lvd_eeprom_stimer_event(evt[15:12]),
      .atimer_event(evt[18:16]));
   iefb_core_model core_m (.*);
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk_val(input string n, input logic [7:0] e, input logic [7:0] g);
      samples_checked++;
      if (g !== e) begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask : chk_val
   task automatic chk_resp(input string n, input logic [1:0] e, input logic [1:0] g);
      chk_val(n, {6'h00, e}, {6'h00, g});
   endtask : chk_resp
   task automatic wr_exp(input logic [7:0] a, input logic [7:0] d,
                         input logic [1:0] rs = IEFB_RESP_OKAY);
      @(posedge core_clk);
      s_axi_awaddr  <= {24'h0, a};
      s_axi_wdata   <= {24'h0, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      do begin
         @(posedge core_clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
      chk_resp($sformatf("bresp %h", a), rs, s_axi_bresp);
   endtask : wr_exp
   task automatic rd_exp(input logic [7:0] a, input logic [7:0] e,
                         input logic [1:0] rs = IEFB_RESP_OKAY);
      @(posedge core_clk);
      s_axi_araddr  <= {24'h0, a};
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      do begin
         @(posedge core_clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
      chk_resp($sformatf("rresp %h", a), rs, s_axi_rresp);
      chk_val($sformatf("reg %h", a), e, s_axi_rdata[7:0]);
   endtask : rd_exp
   task automatic pulse(input logic [18:0] m);
      @(posedge core_clk);
      evt <= m;
      @(posedge core_clk);
      evt <= '0;
   endtask : pulse
   task automatic take(input logic [3:0] v, input logic [7:0] c);
      for (int n = 0; n < 100 && taken_cnt == c; n++) @(posedge core_clk);
      chk_val("vector", {4'h0, v}, {4'h0, taken_vec});
   endtask : take
   task automatic results();
      $display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : results
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (20000) @(posedge core_clk);
      error_cnt++;
      $display("watchdog expired");
      results();
   end
   initial begin
      {nrst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {s_axi_awaddr, s_axi_wdata, s_axi_araddr, ext_pin, evt, ack_delay} = '0;
      s_axi_wstrb = 4'hF;
      repeat (8) @(posedge core_clk);
      nrst <= 1'b1;
      foreach (ROWS[i]) rd_exp(ROWS[i].a, 8'h00, ROWS[i].rs);
      pulse(19'h7FFFF);
      foreach (ROWS[i]) rd_exp(ROWS[i].a, ROWS[i].ev, ROWS[i].rs);
      foreach (ROWS[i]) begin
         wr_exp(ROWS[i].a, ROWS[i].wd, ROWS[i].rs);
         rd_exp(ROWS[i].a, ROWS[i].rd, ROWS[i].rs);
      end
      for (int i = 9; i >= 0; i--) wr_exp(ROWS[i].a, 8'h00, ROWS[i].rs);
      foreach (ROWS[i]) rd_exp(ROWS[i].a, 8'h00, ROWS[i].rs);
      $display("register table done");
      for (int c = 0; c < 4; c++) begin
         wr_exp(IEFB_OFS_EDGE45, {4'h0, c[1:0], c[1:0]}, IEFB_RESP_OKAY);
         wr_exp(IEFB_OFS_CTRL2, 8'h00, IEFB_RESP_OKAY);
         ext_pin <= 6'h3C;
         repeat (4) @(posedge core_clk);
         rd_exp(IEFB_OFS_CTRL2, {{2{c[0]}}, 6'h00}, IEFB_RESP_OKAY);
         ext_pin <= 6'h00;
         repeat (4) @(posedge core_clk);
         rd_exp(IEFB_OFS_CTRL2, {{2{c[0] | c[1]}}, 6'h00}, IEFB_RESP_OKAY);
      end
      rd_exp(IEFB_OFS_GRP3, 8'h30, IEFB_RESP_OKAY);
      wr_exp(IEFB_OFS_GRP3, 8'h00, IEFB_RESP_OKAY);
      $display("edge select done");
      pulse(19'h00005);
      wr_exp(IEFB_OFS_CTRL0, 8'h5A);
      repeat (3) @(posedge core_clk);
      chk_val("request", 8'h00, {7'h0, irq_req});
      cnt_q = taken_cnt;
      wr_exp(IEFB_OFS_CTRL0, 8'h5B);
      take(IEFB_VEC_PIN0, cnt_q);
      rd_exp(IEFB_OFS_CTRL0, 8'h4A);
      ack_delay <= 4'hF;
      cnt_q = taken_cnt;
      wr_exp(IEFB_OFS_CTRL0, 8'h4B);
      rd_exp(IEFB_OFS_VECTOR, {1'b1, 3'h0, IEFB_VEC_ADC});
      take(IEFB_VEC_ADC, cnt_q);
      pulse(19'h00001);
      rd_exp(IEFB_OFS_CTRL0, 8'h1A);
      chk_val("request", 8'h00, {7'h0, irq_req});
      wr_exp(IEFB_OFS_GRP0, 8'h01);
      wr_exp(IEFB_OFS_CTRL1, 8'h01);
      pulse(19'h00100);
      rd_exp(IEFB_OFS_CTRL1, 8'h11);
      cnt_q = taken_cnt;
      wr_exp(IEFB_OFS_CTRL0, 8'h01);
      take(IEFB_VEC_GRP0, cnt_q);
      rd_exp(IEFB_OFS_GRP0, 8'h11);
      wr_exp(IEFB_OFS_GRP0, 8'h00);
      wr_exp(IEFB_OFS_CTRL1, 8'h00);
      rd_exp(IEFB_OFS_CTRL1, 8'h00);
      $display("interrupt service done");
      s_axi_wstrb <= 4'h0;
      wr_exp(IEFB_OFS_CTRL1, 8'hFF);
      s_axi_wstrb <= 4'hF;
      rd_exp(IEFB_OFS_CTRL1, 8'h00);
      wr_exp(IEFB_OFS_CTRL2, 8'hFF);
      nrst <= 1'b0;
      repeat (8) @(posedge core_clk);
      nrst <= 1'b1;
      rd_exp(IEFB_OFS_CTRL2, 8'h00);
      $display("strobe and reset done");
      results();
   end
endmodule : testbench
